/* File: hdl/pmc_pkg.sv */
// constants, field layouts and enumerations of the phy mac-side block
// How it works
// - mii moves 4-bit nibbles on separate transmit and receive paths
// - in mii, carrier sense rises while receiving or transmitting
// - half duplex: collision asserts when transmit and receive overlap
// - rmii slave runs from the 50 mhz clock on the reference pin
// - rmii master derives a 50 mhz clock and drives it on a pin
// - strapped rmii master enables the 50 mhz clock on pin three
// - rmii carries two bits per reference cycle each way
// - rmii transmit dibits latched on reference clock edges
// - rmii at 10 mbps samples and presents data every 10th cycle
// - rmii gives a receive-valid output besides carrier-sense/valid
// - rmii also drives a receive-error output
// - rmii receive data passes through an elastic buffer
// - elastic start threshold selectable as 1 to 4 nibbles in rmii, fixed at 1 in mii
// - 3-bit fields in two pin-mux registers choose each pin's clock
// - interface-rate clock: 25 mhz mii, 50 mhz rmii
// - pass-through clock copies the reference pin clock after the three-stage synchroniser and a register
// - free-running clock option independent of link state
// - recovered clock option follows the clock from the line
// - all internal timing comes from the local clock; pass-through is also resampled on it through the synchroniser
package pmc_pkg;
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int MII_CLK_HZ = 25_000_000;
  localparam int RMII_CLK_HZ = 50_000_000;
  // half periods in system cycles
  localparam int MII_HALF = SYS_CLK_HZ / (2 * MII_CLK_HZ);
  localparam int RMII_HALF = SYS_CLK_HZ / (2 * RMII_CLK_HZ);
  localparam int SLOW_DIV = 10;
  localparam int STRAP_WAIT = 4;
  localparam int NIB_W = 4;
  localparam int EBUF_W = 5;
  localparam int EBUF_DEPTH = 8;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_PINMUX_ONE = 12'h462;
  localparam logic [11:0] IDX_PINMUX_TWO = 12'h463;
  localparam logic [11:0] IDX_CTL = 12'h464;
  localparam logic [11:0] IDX_STAT = 12'h465;
  localparam logic [15:0] ADDR_PINMUX_ONE = {2'h0, IDX_PINMUX_ONE, 2'h0};
  localparam int F_PIN3_LSB = 12;
  localparam int F_PIN1_LSB = 4;
  localparam int F_PIN2_LSB = 4;
  localparam int CTL_THR_LSB = 0;
  localparam int CTL_HDX_BIT = 2;
  localparam int CTL_SLOW_BIT = 3;
  localparam int STAT_OVF_BIT = 4;
  localparam logic [15:0] PINMUX_ONE_RST = 16'h0000;
  localparam logic [15:0] PINMUX_TWO_RST = 16'h0000;
  localparam logic [15:0] CTL_RST = 16'h0000;
  typedef enum logic [2:0] {
    PMC_OPT_PIN = 3'b000,
    PMC_OPT_IFCLK = 3'b001,
    PMC_OPT_PASS = 3'b010,
    PMC_OPT_FREE = 3'b011,
    PMC_OPT_REC = 3'b100
  } pmc_opt_e;
  typedef enum logic [1:0] {
    PMC_MODE_MII = 2'b00,
    PMC_MODE_RMII_SLV = 2'b01,
    PMC_MODE_RMII_MST = 2'b10
  } pmc_mode_e;
endpackage

/* File: hdl/pmc_ebuf_if.sv */
// link between the main block and its elastic receive buffer
`timescale 1ns/1ps
interface pmc_ebuf_if #(
  parameter int W = 5,
  parameter int DEPTH = 8
);
  logic push_valid;
  logic [W-1:0] push_data;
  logic full;
  logic pop;
  logic [W-1:0] head;
  logic empty;
  logic [$clog2(DEPTH+1)-1:0] level;
  modport fill (
    output push_valid, push_data, pop,
    input full, head, empty, level
  );
  modport store (
    input push_valid, push_data, pop,
    output full, head, empty, level
  );
endinterface

/* File: hdl/pmc_sync.sv */
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pmc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } pmc_sync_s;
  pmc_sync_s q;
  pmc_sync_s d;

  always_comb
  begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (q.s2[i] == q.s3[i])
        d.val[i] = q.s3[i];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign dout = q.val;
endmodule

/* File: hdl/pmc_ebuf.sv */
// elastic receive buffer; head of queue is held in a register
`timescale 1ns/1ps
module pmc_ebuf #(
  parameter int W = 5,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // queue access
  pmc_ebuf_if.store bus
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [LW-1:0] level;
    logic [W-1:0] head;
  } pmc_ebuf_s;
  pmc_ebuf_s q;
  pmc_ebuf_s d;
  logic do_push;
  logic do_pop;

  // a push into a full queue is dropped; the caller flags it
  assign do_push = bus.push_valid && !bus.full;
  assign do_pop = bus.pop && !bus.empty;

  always_comb
  begin
    d = q;
    if (do_push)
    begin
      d.mem[q.wptr] = bus.push_data;
      d.wptr = q.wptr + 1'b1;
    end
    if (do_pop)
      d.rptr = q.rptr + 1'b1;
    if (do_push && !do_pop)
      d.level = q.level + 1'b1;
    else if (do_pop && !do_push)
      d.level = q.level - 1'b1;
    d.head = d.mem[d.rptr];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign bus.full = (q.level == LW'(DEPTH));
  assign bus.empty = (q.level == '0);
  assign bus.level = q.level;
  assign bus.head = q.head;
endmodule

/* File: hdl/pmc_top.sv */
// mac-side interface of the phy: mii/rmii data paths, buffer, clock pins
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module pmc_top #(
  parameter int EBUF_DEPTH = pmc_pkg::EBUF_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb register port
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // board pins
  input wire logic reference_clock_input_pin,
  input wire logic [1:0] mode_strap,
  // from the mac
  input wire logic mac_tx_en,
  input wire logic [3:0] mac_txd,
  // to the mac
  output logic [2:0] mac_rxd,
  output logic mac_rx_dv,
  output logic mac_crs,
  output logic mac_rx_er,
  output logic general_pin_one,
  output logic general_pin_two,
  output logic general_pin_three,
  // line side, receive
  input wire logic line_rx_valid,
  input wire logic [3:0] line_rx_data,
  input wire logic line_rx_err,
  input wire logic line_rx_active,
  input wire logic line_rec_clk_tick,
  // line side, transmit
  output logic line_tx_en,
  output logic line_tx_valid,
  output logic [3:0] line_tx_data
);
  localparam int LW = $clog2(EBUF_DEPTH+1);
  typedef struct packed {
    pmc_pkg::pmc_mode_e mode;
    logic [2:0] strap_cnt;
    logic strap_done;
    logic [15:0] mux1;
    logic [15:0] mux2;
    logic [15:0] ctl;
    logic ovf;
    logic [31:0] prdata;
    logic pslverr;
    logic ref_prev;
    logic [1:0] hcnt;
    logic mclk;
    logic [3:0] slow_cnt;
    logic tx_en;
    logic tx_ph;
    logic [1:0] tx_lo;
    logic [3:0] tx_nib;
    logic tx_vld;
    logic rx_run;
    logic rx_ph;
    logic [3:0] rxd;
    logic rx_dv;
    logic rx_er;
    logic crs;
    logic col;
    logic free_clk;
    logic rec_clk;
    logic gp1;
    logic gp2;
    logic gp3;
  } pmc_top_s;
  pmc_top_s q;
  pmc_top_s d;

  logic [1:0] strap_s;
  logic ref_s;
  logic txen_s;
  logic [3:0] txd_s;
  logic is_mii;
  logic [1:0] half_m1;
  logic hwrap;
  logic base_tick;
  logic dtick;
  logic ifclk;
  logic [LW-1:0] thr_need;
  logic start_ok;
  logic setup;
  logic access;
  logic [11:0] idx;
  logic aligned;
  logic hit;
  logic [31:0] rd_val;

  pmc_ebuf_if #(.W(pmc_pkg::EBUF_W), .DEPTH(EBUF_DEPTH)) eb ();

  pmc_sync #(.W(8)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .din({mode_strap, reference_clock_input_pin, mac_tx_en, mac_txd}),
    .dout({strap_s, ref_s, txen_s, txd_s})
  );

  pmc_ebuf #(.W(pmc_pkg::EBUF_W), .DEPTH(EBUF_DEPTH)) u_ebuf (
    .sys_clk(sys_clk),
    .rst(rst),
    .bus(eb.store)
  );

  assign is_mii = (q.mode == pmc_pkg::PMC_MODE_MII);
  assign half_m1 = is_mii ? 2'(pmc_pkg::MII_HALF - 1)
                          : 2'(pmc_pkg::RMII_HALF - 1);
  // the mode change at capture can leave the count above the new limit
  assign hwrap = (q.hcnt >= half_m1);
  assign base_tick = q.strap_done &&
    ((q.mode == pmc_pkg::PMC_MODE_RMII_SLV) ? (ref_s && !q.ref_prev)
                                            : (hwrap && !q.mclk));
  // every tenth tick at 10 mbps
  assign dtick = base_tick && (!q.ctl[pmc_pkg::CTL_SLOW_BIT] ||
    q.slow_cnt == 4'(pmc_pkg::SLOW_DIV - 1));
  assign ifclk = (q.mode == pmc_pkg::PMC_MODE_RMII_SLV) ? ref_s : q.mclk;

  assign thr_need = is_mii ? LW'(1)
    : LW'(q.ctl[pmc_pkg::CTL_THR_LSB +: 2]) + LW'(1);
  // a short frame that ends below threshold must still be released
  assign start_ok = (eb.level >= thr_need) ||
    (!line_rx_active && !eb.empty);

  // line nibbles enter the elastic buffer
  assign eb.push_valid = line_rx_valid;
  assign eb.push_data = {line_rx_err, line_rx_data};
  assign eb.pop = dtick && q.rx_run && !eb.empty && (is_mii || q.rx_ph);

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign idx = paddr[13:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
  assign hit = aligned && (idx == pmc_pkg::IDX_PINMUX_ONE ||
    idx == pmc_pkg::IDX_PINMUX_TWO || idx == pmc_pkg::IDX_CTL ||
    idx == pmc_pkg::IDX_STAT);

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (aligned)
    begin
      case (idx)
        pmc_pkg::IDX_PINMUX_ONE: rd_val = {16'h0000, q.mux1};
        pmc_pkg::IDX_PINMUX_TWO: rd_val = {16'h0000, q.mux2};
        pmc_pkg::IDX_CTL: rd_val = {16'h0000, q.ctl};
        pmc_pkg::IDX_STAT:
          rd_val = 32'({LW'(eb.level), q.ovf, q.tx_en, q.rx_run,
                        q.mode});
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  function automatic logic pick(input logic [2:0] sel, input logic normal,
                                input logic ifc, input logic pass,
                                input logic fr, input logic rc);
    case (sel)
      pmc_pkg::PMC_OPT_PIN: pick = normal;
      pmc_pkg::PMC_OPT_IFCLK: pick = ifc;
      pmc_pkg::PMC_OPT_PASS: pick = pass;
      pmc_pkg::PMC_OPT_FREE: pick = fr;
      pmc_pkg::PMC_OPT_REC: pick = rc;
      default: pick = normal;
    endcase
  endfunction

  always_comb
  begin
    d = q;
    d.ref_prev = ref_s;
    d.tx_vld = 1'b0;

    if (!q.strap_done)
    begin
      d.strap_cnt = q.strap_cnt + 1'b1;
      if (q.strap_cnt == 3'(pmc_pkg::STRAP_WAIT))
      begin
        d.strap_done = 1'b1;
        case (strap_s)
          2'h1: d.mode = pmc_pkg::PMC_MODE_RMII_SLV;
          2'h2: d.mode = pmc_pkg::PMC_MODE_RMII_MST;
          default: d.mode = pmc_pkg::PMC_MODE_MII;
        endcase
        if (strap_s == 2'h2)
          d.mux1[pmc_pkg::F_PIN3_LSB +: 3] = pmc_pkg::PMC_OPT_IFCLK;
      end
    end

    if (hwrap)
    begin
      d.hcnt = 2'h0;
      d.mclk = !q.mclk;
    end
    else
      d.hcnt = q.hcnt + 1'b1;
    if (base_tick)
      d.slow_cnt = (q.slow_cnt == 4'(pmc_pkg::SLOW_DIV - 1))
                   ? 4'h0 : q.slow_cnt + 1'b1;

    // apb: answer prepared in setup, taken at the access edge
    if (setup)
    begin
      d.pslverr = !hit;
      if (!pwrite)
        d.prdata = rd_val;
    end
    // overrun is sticky; a new one wins over the clearing write
    if (access && pwrite && hit && idx == pmc_pkg::IDX_STAT &&
        pwdata[pmc_pkg::STAT_OVF_BIT])
      d.ovf = 1'b0;
    if (line_rx_valid && eb.full)
      d.ovf = 1'b1;
    if (access && pwrite && hit)
    begin
      case (idx)
        pmc_pkg::IDX_PINMUX_ONE: d.mux1 = pwdata[15:0];
        pmc_pkg::IDX_PINMUX_TWO: d.mux2 = pwdata[15:0];
        pmc_pkg::IDX_CTL: d.ctl = pwdata[15:0];
        default: d.ctl = q.ctl;
      endcase
    end

    if (dtick)
    begin
      d.tx_en = txen_s;
      if (!txen_s)
        d.tx_ph = 1'b0;
      else if (is_mii)
      begin
        d.tx_nib = txd_s;
        d.tx_vld = 1'b1;
      end
      else if (!q.tx_ph)
      begin
        d.tx_lo = txd_s[1:0];
        d.tx_ph = 1'b1;
      end
      else
      begin
        d.tx_nib = {txd_s[1:0], q.tx_lo};
        d.tx_vld = 1'b1;
        d.tx_ph = 1'b0;
      end
    end

    if (dtick)
    begin
      if (!q.rx_run)
      begin
        d.rx_dv = 1'b0;
        d.rx_er = 1'b0;
        if (start_ok)
        begin
          d.rx_run = 1'b1;
          d.rx_ph = 1'b0;
        end
      end
      else if (eb.empty)
      begin
        d.rx_run = 1'b0;
        d.rx_dv = 1'b0;
        // running dry mid-frame is an underrun
        d.rx_er = line_rx_active;
      end
      else
      begin
        d.rx_dv = 1'b1;
        d.rx_er = eb.head[pmc_pkg::NIB_W];
        if (is_mii)
          d.rxd = eb.head[3:0];
        else
        begin
          d.rxd[1:0] = q.rx_ph ? eb.head[3:2] : eb.head[1:0];
          d.rx_ph = !q.rx_ph;
        end
      end
    end

    d.crs = line_rx_active || q.rx_run || (is_mii && txen_s);
    d.col = q.ctl[pmc_pkg::CTL_HDX_BIT] && txen_s && line_rx_active;

    d.free_clk = !q.free_clk;
    if (line_rec_clk_tick)
      d.rec_clk = !q.rec_clk;
    d.gp1 = pick(q.mux1[pmc_pkg::F_PIN1_LSB +: 3], q.crs, ifclk, ref_s,
                 q.free_clk, q.rec_clk);
    d.gp2 = pick(q.mux2[pmc_pkg::F_PIN2_LSB +: 3], q.col, ifclk, ref_s,
                 q.free_clk, q.rec_clk);
    d.gp3 = pick(q.mux1[pmc_pkg::F_PIN3_LSB +: 3], q.rxd[3], ifclk, ref_s,
                 q.free_clk, q.rec_clk);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.mode <= pmc_pkg::PMC_MODE_MII;
      q.mux1 <= pmc_pkg::PINMUX_ONE_RST;
      q.mux2 <= pmc_pkg::PINMUX_TWO_RST;
      q.ctl <= pmc_pkg::CTL_RST;
    end
    else
      q <= d;
  end

  assign pready = 1'b1;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign mac_rxd = q.rxd[2:0];
  assign mac_rx_dv = q.rx_dv;
  assign mac_crs = q.crs;
  assign mac_rx_er = q.rx_er;
  assign general_pin_one = q.gp1;
  assign general_pin_two = q.gp2;
  assign general_pin_three = q.gp3;
  assign line_tx_en = q.tx_en;
  assign line_tx_valid = q.tx_vld;
  assign line_tx_data = q.tx_nib;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_mode_fixed;
    q.strap_done |=> $stable(q.mode) && q.strap_done;
  endproperty
  a_mode_fixed: assert property (p_mode_fixed)
    else $error("interface mode changed after capture");

  property p_crs;
    (is_mii && txen_s) |=> mac_crs;
  endproperty
  a_crs: assert property (p_crs)
    else $error("carrier sense low while transmitting");

  property p_col;
    (q.ctl[pmc_pkg::CTL_HDX_BIT] && txen_s && line_rx_active &&
     q.mux2[pmc_pkg::F_PIN2_LSB +: 3] == pmc_pkg::PMC_OPT_PIN &&
     $stable(q.mux2)) |=> ##1 general_pin_two;
  endproperty
  a_col: assert property (p_col)
    else $error("collision not shown on pin two");

  property p_slow;
    (dtick && q.ctl[pmc_pkg::CTL_SLOW_BIT] && $stable(q.ctl))
      |=> !dtick [*8];
  endproperty
  a_slow: assert property (p_slow)
    else $error("slow data tick came too soon");

  property p_pair;
    (!is_mii && dtick && txen_s && q.tx_ph) |=>
      line_tx_valid && line_tx_data[3:2] == $past(txd_s[1:0]);
  endproperty
  a_pair: assert property (p_pair)
    else $error("dibit pair not assembled");

  property p_start;
    $rose(q.rx_run) |-> $past(start_ok) && $past(dtick);
  endproperty
  a_start: assert property (p_start)
    else $error("receive started below threshold");

  property p_strap_clk;
    ($rose(q.strap_done) && q.mode == pmc_pkg::PMC_MODE_RMII_MST)
      |-> q.mux1[pmc_pkg::F_PIN3_LSB +: 3] == pmc_pkg::PMC_OPT_IFCLK
          ##2 general_pin_three != $past(general_pin_three);
  endproperty
  a_strap_clk: assert property (p_strap_clk)
    else $error("strapped master clock missing on pin three");

  property p_pass;
    (q.mux1[pmc_pkg::F_PIN1_LSB +: 3] == pmc_pkg::PMC_OPT_PASS)
      |=> general_pin_one == $past(ref_s);
  endproperty
  a_pass: assert property (p_pass)
    else $error("pass-through clock not copied");

  sequence s_wr_mux1;
    setup && pwrite && paddr == pmc_pkg::ADDR_PINMUX_ONE ##1 access;
  endsequence
  property p_wr_mux1;
    s_wr_mux1 |=> q.mux1 == $past(pwdata[15:0]);
  endproperty
  a_wr_mux1: assert property (p_wr_mux1)
    else $error("pin-mux write not stored");
endmodule

/* File: dv/pmc_mac_model.sv */
// behavioural mac on the far side of the mii/rmii data paths
`timescale 1ns/1ps
module pmc_mac_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bench control
  input wire logic go,
  input wire logic [3:0] nib,
  output logic [3:0] rx_seen,
  // mac pins
  output logic mac_tx_en,
  output logic [3:0] mac_txd,
  input wire logic mac_rx_dv,
  input wire logic [2:0] mac_rxd,
  input wire logic pin3
);
  logic [3:0] last_q;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mac_tx_en <= 1'b0;
      mac_txd <= 4'h0;
      last_q <= 4'h0;
    end
    else if (go)
    begin
      mac_tx_en <= 1'b1;
      mac_txd <= nib;
      last_q <= nib;
    end
    else
    begin
      // released lines show the inverse so stale data never matches
      mac_tx_en <= 1'b0;
      mac_txd <= ~last_q;
    end
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rx_seen <= 4'h0;
    else if (mac_rx_dv)
      rx_seen <= {pin3, mac_rxd};
  end
endmodule

/* File: dv/pmc_top_tb.sv */
// self-checking bench for the mac-side block
`timescale 1ns/1ps
module pmc_top_tb;
  typedef struct {
    logic [15:0] addr;
    logic [15:0] wd;
    int pin;
    int cyc;
    int lo;
    int hi;
  } pmc_row_s;
  localparam logic [15:0] A1 = pmc_pkg::ADDR_PINMUX_ONE;
  localparam logic [15:0] A2 = {2'h0, pmc_pkg::IDX_PINMUX_TWO, 2'h0};
  localparam logic [15:0] AC = {2'h0, pmc_pkg::IDX_CTL, 2'h0};
  localparam logic [15:0] AS = {2'h0, pmc_pkg::IDX_STAT, 2'h0};
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, ref_pin;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] mode_strap;
  logic go, mac_tx_en, mac_rx_dv, mac_crs, mac_rx_er, gp1, gp2, gp3;
  logic [3:0] nib, rx_seen, mac_txd, lrd, line_tx_data;
  logic [2:0] mac_rxd;
  logic lrv, lre, lra, ltick, line_tx_en, line_tx_valid;
  logic [1:0] tick_cnt;
  int err_total, comparisons;
  pmc_row_s rows [5];

  pmc_top pmc_top_inst (
    .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_clock_input_pin(ref_pin), .mode_strap(mode_strap),
    .mac_tx_en(mac_tx_en), .mac_txd(mac_txd), .mac_rxd(mac_rxd),
    .mac_rx_dv(mac_rx_dv), .mac_crs(mac_crs), .mac_rx_er(mac_rx_er),
    .general_pin_one(gp1), .general_pin_two(gp2),
    .general_pin_three(gp3), .line_rx_valid(lrv), .line_rx_data(lrd),
    .line_rx_err(lre), .line_rx_active(lra), .line_rec_clk_tick(ltick),
    .line_tx_en(line_tx_en), .line_tx_valid(line_tx_valid),
    .line_tx_data(line_tx_data));
  pmc_mac_model pmc_mac_model_inst (
    .sys_clk(sys_clk), .rst(rst), .go(go), .nib(nib),
    .rx_seen(rx_seen), .mac_tx_en(mac_tx_en), .mac_txd(mac_txd),
    .mac_rx_dv(mac_rx_dv), .mac_rxd(mac_rxd), .pin3(gp3));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // link-side reference, unrelated in phase to the system clock
  initial
  begin
    ref_pin = 1'b0;
    #3;
    forever #62.5 ref_pin = ~ref_pin;
  end
  always @(posedge sys_clk)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    ltick <= (tick_cnt == 2'h0);
  end

  task automatic give_verdict();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic [15:0] a, input logic w,
                     input logic [15:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge sys_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= {16'h0, d};
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      err_total++;
      give_verdict();
    end
  endtask
  function automatic logic sel(input int k);
    case (k)
      1: sel = gp1;
      2: sel = gp2;
      3: sel = gp3;
      4: sel = mac_crs;
      5: sel = mac_rx_dv;
      6: sel = mac_rx_er;
      default: sel = line_tx_valid;
    endcase
  endfunction
  task automatic wait_hi(input string nm, input int k);
    int n;
    n = 0;
    while (sel(k) !== 1'b1 && n < 300)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(nm, {31'h0, sel(k)}, 32'h1);
    if (n >= 300)
      give_verdict();
  endtask
  // counts rising edges of a watched output over a fixed span
  task automatic rises(input string nm, input int k, input int cyc,
                       input int lo, input int hi);
    logic p;
    int n;
    n = 0;
    p = sel(k);
    repeat (cyc)
    begin
      @(posedge sys_clk);
      #1;
      if (sel(k) === 1'b1 && p !== 1'b1)
        n++;
      p = sel(k);
    end
    check(nm, {31'h0, (n >= lo && n <= hi)}, 32'h1);
  endtask
  task automatic push(input logic [3:0] d);
    @(posedge sys_clk);
    lrv <= 1'b1;
    lrd <= d;
    @(posedge sys_clk);
    lrv <= 1'b0;
  endtask
  task automatic do_reset(input logic [1:0] s);
    @(posedge sys_clk);
    rst <= 1'b1;
    mode_strap <= s;
    repeat (10) @(posedge sys_clk);
    #1;
    check("pready in reset", {31'h0, pready}, 32'h1);
    check("rx_dv in reset", {31'h0, mac_rx_dv}, 32'h0);
    @(posedge sys_clk);
    rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
  endtask

  initial
  begin
    logic [31:0] rd;
    logic er;
    int i;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    mode_strap = 2'h0;
    go = 1'b0;
    nib = 4'h0;
    lrv = 1'b0;
    lrd = 4'h0;
    lre = 1'b0;
    lra = 1'b0;
    ltick = 1'b0;
    tick_cnt = 2'h0;
    err_total = 0;
    comparisons = 0;
    rows[0] = '{A1, 16'h0010, 1, 80, 19, 21};
    rows[1] = '{A2, 16'h0020, 2, 400, 31, 33};
    rows[2] = '{A1, 16'h3000, 3, 80, 39, 41};
    rows[3] = '{A1, 16'h0040, 1, 80, 9, 11};
    rows[4] = '{A1, 16'h0020, 1, 400, 31, 33};
    do_reset(2'h0);
    apb(A1, 1'b0, 16'h0, rd, er);
    check("pinmux one reset", rd, 32'h0);
    apb(A2, 1'b0, 16'h0, rd, er);
    check("pinmux two reset", rd, 32'h0);
    apb(16'h0000, 1'b0, 16'h0, rd, er);
    check("unmapped err", {31'h0, er}, 32'h1);
    apb(16'h1189, 1'b1, 16'h1, rd, er);
    check("misaligned err", {31'h0, er}, 32'h1);
    for (i = 0; i < 5; i++)
    begin
      apb(rows[i].addr, 1'b1, rows[i].wd, rd, er);
      apb(rows[i].addr, 1'b0, 16'h0, rd, er);
      check("pinmux readback", rd, {16'h0, rows[i].wd});
      rises("clock option", rows[i].pin, rows[i].cyc, rows[i].lo,
            rows[i].hi);
    end
    apb(A1, 1'b1, 16'h0, rd, er);
    apb(A2, 1'b1, 16'h0, rd, er);
    go <= 1'b1;
    nib <= 4'ha;
    repeat (20) @(posedge sys_clk);
    wait_hi("mii tx valid", 0);
    check("mii tx nibble", {28'h0, line_tx_data}, 32'ha);
    check("tx enable", {31'h0, line_tx_en}, 32'h1);
    wait_hi("crs on tx", 4);
    apb(AC, 1'b1, 16'h0004, rd, er);
    lra <= 1'b1;
    wait_hi("collision", 2);
    @(posedge sys_clk);
    go <= 1'b0;
    apb(AC, 1'b1, 16'h0000, rd, er);
    repeat (20) @(posedge sys_clk);
    push(4'h5);
    wait_hi("mii rx valid", 5);
    repeat (2) @(posedge sys_clk);
    #1;
    check("mii rx nibble", {28'h0, rx_seen}, 32'h5);
    @(posedge sys_clk);
    lra <= 1'b0;
    mode_strap <= 2'h2;
    repeat (10) @(posedge sys_clk);
    apb(AS, 1'b0, 16'h0, rd, er);
    check("mode held", rd & 32'h3, 32'h0);
    do_reset(2'h2);
    apb(AS, 1'b0, 16'h0, rd, er);
    check("mode master", rd & 32'h3, 32'h2);
    apb(A1, 1'b0, 16'h0, rd, er);
    check("strap pin three", rd, 32'h1000);
    rises("master clock", 3, 80, 39, 41);
    @(posedge sys_clk);
    go <= 1'b1;
    nib <= 4'h1;
    repeat (40) @(posedge sys_clk);
    wait_hi("rmii tx valid", 0);
    check("rmii dibit pair", {28'h0, line_tx_data}, 32'h5);
    rises("fast tx rate", 0, 400, 99, 101);
    apb(AC, 1'b1, 16'h0008, rd, er);
    repeat (40) @(posedge sys_clk);
    rises("slow tx rate", 0, 400, 9, 11);
    @(posedge sys_clk);
    go <= 1'b0;
    // stay at 10 mbps: receive is then paced by the slow tick as well
    apb(AC, 1'b1, 16'h000b, rd, er);
    lra <= 1'b1;
    push(4'h1);
    push(4'h2);
    push(4'h3);
    rises("below threshold", 5, 40, 0, 0);
    push(4'h4);
    wait_hi("threshold start", 5);
    check("crs_dv with dv", {31'h0, mac_crs}, 32'h1);
    wait_hi("underrun error", 6);
    @(posedge sys_clk);
    lra <= 1'b0;
    do_reset(2'h1);
    apb(AS, 1'b0, 16'h0, rd, er);
    check("mode slave", rd & 32'h3, 32'h1);
    go <= 1'b1;
    repeat (40) @(posedge sys_clk);
    rises("slave tx rate", 0, 400, 15, 17);
    give_verdict();
  end
endmodule
